/* File: rtl/qss_status.sv */
// Status, counts, interrupt enables and sideband pins of the quad serial master
`timescale 1ns/100ps
module qss_status
  import qss_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  // Link clock pin
  input  wire logic                 link_clk,
  // Engine controls
  input  wire logic                 start_req,
  input  wire logic                 stop_req,
  input  wire logic [15:0]          xfer_len,
  input  wire logic                 close_en,
  input  wire logic                 desc_en,
  input  wire logic                 desc_last,
  input  wire logic [3:0]           desc_idx,
  input  wire logic                 tx_dma_en,
  input  wire logic                 rx_dma_en,
  input  wire logic                 tx_dma_done,
  input  wire logic                 rx_dma_done,
  input  wire logic                 prog_err,
  // FIFO occupancy and events
  input  wire logic [QSS_CNT_W-1:0] rx_count,
  input  wire logic [QSS_CNT_W-1:0] tx_count,
  input  wire logic                 rx_full,
  input  wire logic                 tx_full,
  input  wire logic                 rx_push_try,
  input  wire logic                 tx_pop_try,
  input  wire logic                 rx_read_try,
  input  wire logic                 tx_write_try,
  // Sideband pins
  output logic                      hold_out,
  output logic                      hold_oe,
  output logic                      wp_out,
  output logic                      wp_oe,
  // Interrupt and activity
  output logic                      irq,
  output logic                      xfer_active
);
  qss_state_e  state;
  qss_state_e  next_state;
  logic [3:0]  sideband;
  logic [3:0]  next_sideband;
  logic [15:0] flags;
  logic [15:0] next_flags;
  logic [15:0] ien;
  logic [15:0] next_ien;
  logic [31:0] trig;
  logic [31:0] next_trig;
  logic [15:0] byte_cnt;
  logic [15:0] next_byte_cnt;
  logic        stop_pend;
  logic        next_stop_pend;
  logic        tx_dma_seen;
  logic        next_tx_dma_seen;
  logic        rx_dma_seen;
  logic        next_rx_dma_seen;
  logic [31:0] next_rdata;
  logic        lclk_s;
  logic        lclk_d;
  logic        lclk_rise;
  logic        byte_end;
  logic [2:0]  bit_idx;
  logic [15:0] set_ev;
  logic [15:0] clr_ev;
  logic [15:0] live;
  logic        dma_fire;
  logic        done_fire;
  logic        len_hit;
  logic        rx_empty;
  logic        tx_empty;

  function automatic logic [15:0] pick(input logic [15:0] v, input int pos);
    pick = 16'h0000;
    pick[pos] = v[pos];
  endfunction

  qss_sync #(.W(1)) u_lclk_sync (
    .clk (clk),
    .rst (rst),
    .d   (link_clk),
    .q   (lclk_s)
  );

  qss_bitcnt u_bitcnt (
    .clk       (clk),
    .rst       (rst),
    .clear     (state != QSS_SHIFT),
    .edge_tick (lclk_rise && (state == QSS_SHIFT)),
    .byte_end  (byte_end),
    .bit_idx   (bit_idx)
  );

  assign lclk_rise = lclk_s && !lclk_d;
  assign rx_empty  = (rx_count == '0);
  assign tx_empty  = (tx_count == '0);
  assign len_hit   = byte_end && (xfer_len != 16'h0000) && (byte_cnt + 16'h1 == xfer_len);

  // Transfer sequencing
  always_comb begin
    next_state       = state;
    next_byte_cnt    = byte_cnt;
    next_stop_pend   = stop_pend;
    next_tx_dma_seen = tx_dma_seen || tx_dma_done;
    next_rx_dma_seen = rx_dma_seen || rx_dma_done;
    dma_fire         = 1'b0;
    done_fire        = 1'b0;
    unique case (state)
      QSS_IDLE: begin
        next_byte_cnt    = 16'h0000;
        next_stop_pend   = 1'b0;
        next_tx_dma_seen = 1'b0;
        next_rx_dma_seen = 1'b0;
        if (start_req) begin
          next_state = QSS_SHIFT;
        end
      end
      QSS_SHIFT: begin
        if (stop_req) begin
          next_stop_pend = 1'b1;
        end
        if (byte_end) begin
          next_byte_cnt = byte_cnt + 16'h1;
        end
        // Every enabled direction must have finished
        if ((tx_dma_en || rx_dma_en) && (!tx_dma_en || next_tx_dma_seen)
            && (!rx_dma_en || next_rx_dma_seen)) begin
          dma_fire         = 1'b1;
          next_tx_dma_seen = 1'b0;
          next_rx_dma_seen = 1'b0;
          if (!desc_en || desc_last) begin
            done_fire = 1'b1;
          end
          if (close_en && (!desc_en || desc_last)) begin
            next_state = QSS_DONE;
          end
        end else if (byte_end && (stop_pend || stop_req)) begin
          done_fire  = 1'b1;
          next_state = QSS_DONE;
        end else if (!tx_dma_en && !rx_dma_en && len_hit) begin
          next_byte_cnt = 16'h0000;
          if (!desc_en || desc_last) begin
            done_fire  = 1'b1;
            next_state = QSS_DONE;
          end
        end
      end
      QSS_DONE: begin
        next_state = QSS_IDLE;
      end
      default: begin
        next_state = QSS_IDLE;
      end
    endcase
  end

  // Status flags, enables and register port
  always_comb begin
    set_ev = 16'h0000;
    set_ev[QSS_ST_RX_STALL]  = rx_push_try && rx_full;
    set_ev[QSS_ST_TX_STALL]  = tx_pop_try && tx_empty;
    set_ev[QSS_ST_RX_REQ]    = (trig[31:16] != 16'h0000) && (rx_count >= trig[31:16]);
    set_ev[QSS_ST_TX_REQ]    = (trig[15:0] != 16'h0000) && (tx_count <= trig[15:0]);
    set_ev[QSS_ST_PROG_ERR]  = prog_err;
    set_ev[QSS_ST_RX_ERR]    = rx_read_try && rx_empty;
    set_ev[QSS_ST_TX_ERR]    = tx_write_try && tx_full;
    set_ev[QSS_ST_DMA_DONE]  = dma_fire;
    set_ev[QSS_ST_XFER_DONE] = done_fire;
    clr_ev = (wr && addr == QSS_OFF_STATUS) ? (wdata[15:0] & QSS_WC_MASK) : 16'h0000;
    next_flags = ((flags & ~clr_ev) | set_ev) & QSS_WC_MASK;
    live = flags;
    live[QSS_ST_RX_EMPTY] = rx_empty;
    live[QSS_ST_RX_FULL]  = rx_full;
    live[QSS_ST_TX_EMPTY] = tx_empty && (state != QSS_IDLE || flags[QSS_ST_XFER_DONE]);
    live[QSS_ST_TX_FULL]  = tx_full;
    next_sideband = sideband;
    next_ien      = ien;
    next_trig     = trig;
    if (wr && addr == QSS_OFF_SIDEBAND) begin
      next_sideband = wdata[3:0];
    end
    if (wr && addr == QSS_OFF_IEN) begin
      next_ien = wdata[15:0] & QSS_IEN_MASK;
    end
    if (wr && addr == QSS_OFF_TRIGGER) begin
      next_trig = wdata;
    end
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        QSS_OFF_SIDEBAND: next_rdata = {28'h0, sideband};
        QSS_OFF_STATUS:   next_rdata = {4'h0, desc_idx, 7'h00,
                                        state != QSS_IDLE, live};
        QSS_OFF_COUNTS:   next_rdata = {rx_count, tx_count};
        QSS_OFF_IEN:      next_rdata = {16'h0000, ien};
        QSS_OFF_TRIGGER:  next_rdata = trig;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= QSS_IDLE;
      byte_cnt    <= 16'h0000;
      stop_pend   <= 1'b0;
      tx_dma_seen <= 1'b0;
      rx_dma_seen <= 1'b0;
      sideband    <= QSS_SB_RESET;
      flags       <= 16'h0000;
      ien         <= QSS_IEN_RESET;
      trig        <= QSS_TRIG_RESET;
      rdata       <= 32'h0000_0000;
      lclk_d      <= 1'b0;
    end else begin
      state       <= next_state;
      byte_cnt    <= next_byte_cnt;
      stop_pend   <= next_stop_pend;
      tx_dma_seen <= next_tx_dma_seen;
      rx_dma_seen <= next_rx_dma_seen;
      sideband    <= next_sideband;
      flags       <= next_flags;
      ien         <= next_ien;
      trig        <= next_trig;
      rdata       <= next_rdata;
      lclk_d      <= lclk_s;
    end
  end

  // Pins and interrupt
  assign hold_oe     = sideband[QSS_SB_HOLD_EN];
  assign hold_out    = sideband[QSS_SB_HOLD_EN] & sideband[QSS_SB_HOLD_VAL];
  assign wp_oe       = sideband[QSS_SB_WP_EN];
  assign wp_out      = sideband[QSS_SB_WP_EN] & sideband[QSS_SB_WP_VAL];
  assign irq         = |(live & ien);
  assign xfer_active = (state != QSS_IDLE);

  // Checks
  a_hold_drive: assert property (@(posedge clk) disable iff (rst)
    hold_oe == sideband[QSS_SB_HOLD_EN] && (!hold_oe || hold_out == sideband[QSS_SB_HOLD_VAL]))
    else $error("hold pin drive wrong");
  a_wp_drive: assert property (@(posedge clk) disable iff (rst)
    wp_oe == sideband[QSS_SB_WP_EN] && (!wp_oe || wp_out == sideband[QSS_SB_WP_VAL]))
    else $error("write-protect pin drive wrong");
  a_stall_sticky: assert property (@(posedge clk) disable iff (rst)
    (rx_push_try && rx_full) |=> flags[QSS_ST_RX_STALL])
    else $error("receive stall not flagged");
  a_txstall_sticky: assert property (@(posedge clk) disable iff (rst)
    (tx_pop_try && tx_empty) |=> flags[QSS_ST_TX_STALL])
    else $error("transmit stall not flagged");
  a_rx_request: assert property (@(posedge clk) disable iff (rst)
    (trig[31:16] != 16'h0 && rx_count >= trig[31:16]) |=> flags[QSS_ST_RX_REQ])
    else $error("receive request missing");
  a_tx_error: assert property (@(posedge clk) disable iff (rst)
    (tx_write_try && tx_full) |=> flags[QSS_ST_TX_ERR])
    else $error("transmit overflow missing");
  a_rx_error: assert property (@(posedge clk) disable iff (rst)
    (rx_read_try && rx_empty) |=> flags[QSS_ST_RX_ERR])
    else $error("receive underflow missing");
  a_done_pair: assert property (@(posedge clk) disable iff (rst)
    (dma_fire && close_en && (!desc_en || desc_last)) |-> done_fire)
    else $error("done flags not together");
  a_wc_keep: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == QSS_OFF_STATUS && wdata[0] == 1'b0 && flags[0]) |=> flags[0])
    else $error("zero write cleared flag");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    (ien == 16'h0) |-> !irq)
    else $error("interrupt without enable");
endmodule // qss_status

/* File: include/qss_pkg.sv */
// Constants for the quad serial master status and sideband block
package qss_pkg;
  localparam logic [7:0]  QSS_OFF_SIDEBAND = 8'h0C;
  localparam logic [7:0]  QSS_OFF_STATUS   = 8'h10;
  localparam logic [7:0]  QSS_OFF_COUNTS   = 8'h14;
  localparam logic [7:0]  QSS_OFF_IEN      = 8'h18;
  localparam logic [7:0]  QSS_OFF_TRIGGER  = 8'h1C;
  localparam int          QSS_SB_HOLD_EN   = 3;
  localparam int          QSS_SB_HOLD_VAL  = 2;
  localparam int          QSS_SB_WP_EN     = 1;
  localparam int          QSS_SB_WP_VAL    = 0;
  localparam logic [3:0]  QSS_SB_RESET     = 4'h5;
  localparam int          QSS_ST_DESC_LO   = 24;
  localparam int          QSS_ST_ACTIVE    = 16;
  localparam int          QSS_ST_RX_STALL  = 15;
  localparam int          QSS_ST_RX_REQ    = 14;
  localparam int          QSS_ST_RX_EMPTY  = 13;
  localparam int          QSS_ST_RX_FULL   = 12;
  localparam int          QSS_ST_TX_STALL  = 11;
  localparam int          QSS_ST_TX_REQ    = 10;
  localparam int          QSS_ST_TX_EMPTY  = 9;
  localparam int          QSS_ST_TX_FULL   = 8;
  localparam int          QSS_ST_PROG_ERR  = 4;
  localparam int          QSS_ST_RX_ERR    = 3;
  localparam int          QSS_ST_TX_ERR    = 2;
  localparam int          QSS_ST_DMA_DONE  = 1;
  localparam int          QSS_ST_XFER_DONE = 0;
  localparam logic [15:0] QSS_WC_MASK      = 16'hCC1F;
  localparam logic [15:0] QSS_IEN_MASK     = 16'h771F;
  localparam logic [15:0] QSS_IEN_RESET    = 16'h2000;
  localparam logic [31:0] QSS_TRIG_RESET   = 32'h0000_0000;
  localparam int          QSS_BYTE_BITS    = 8;
  localparam int          QSS_CNT_W        = 16;
  typedef enum logic [2:0] {
    QSS_IDLE  = 3'b001,
    QSS_SHIFT = 3'b010,
    QSS_DONE  = 3'b100
  } qss_state_e;
endpackage

/* File: rtl/qss_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module qss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule // qss_sync

/* File: rtl/qss_bitcnt.sv */
// Bit counter of the serial engine, stepped on rising link clock edges
`timescale 1ns/100ps
module qss_bitcnt
  import qss_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic       edge_tick,
  // Status
  output logic            byte_end,
  output logic [2:0]      bit_idx
);
  logic [2:0] next_bit_idx;

  always_comb begin
    byte_end     = edge_tick && (bit_idx == 3'(QSS_BYTE_BITS - 1));
    next_bit_idx = bit_idx;
    if (clear) begin
      next_bit_idx = 3'h0;
    end else if (edge_tick) begin
      next_bit_idx = bit_idx + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_idx <= 3'h0;
    end else begin
      bit_idx <= next_bit_idx;
    end
  end
endmodule // qss_bitcnt

/* File: verification/qss_flash_model.sv */
// Far-side serial flash model: link clock and sideband pin levels
`timescale 1ns/100ps
module qss_flash_model (
  // Frame control
  input  wire logic run,
  // Sideband pins from the block
  input  wire logic hold_out,
  input  wire logic hold_oe,
  input  wire logic wp_out,
  input  wire logic wp_oe,
  // Link clock and resolved pins
  output logic      link_clk,
  output logic      hold_pin,
  output logic      wp_pin
);
  // Link clock toggles only inside a frame, 320 ns period
  initial begin
    link_clk = 1'b0;
    forever begin
      #160;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  // Pull-ups hold the pins high while undriven
  assign hold_pin = hold_oe ? hold_out : 1'b1;
  assign wp_pin   = wp_oe ? wp_out : 1'b1;
endmodule // qss_flash_model

/* File: verification/tb.sv */
// Register-level bench for the status and sideband block
`timescale 1ns/100ps
module tb;
  import qss_pkg::*;
  logic        clk, rst, wr, rd, run, link_clk;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [8:0]  ev;
  logic [15:0] xfer_len, rx_count, tx_count;
  logic [3:0]  desc_idx;
  logic        desc_en, tx_dma_en, rx_dma_en, rx_full, tx_full, close_en, desc_last;
  logic        hold_out, hold_oe, wp_out, wp_oe, hold_pin, wp_pin, irq;
  int          err_count, checks;

  qss_status i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link_clk(link_clk), .start_req(ev[5]), .stop_req(ev[6]),
    .xfer_len(xfer_len), .close_en(close_en), .desc_en(desc_en), .desc_last(desc_last),
    .desc_idx(desc_idx), .tx_dma_en(tx_dma_en), .rx_dma_en(rx_dma_en),
    .tx_dma_done(ev[7]), .rx_dma_done(ev[8]), .prog_err(ev[4]), .rx_count(rx_count),
    .tx_count(tx_count), .rx_full(rx_full), .tx_full(tx_full), .rx_push_try(ev[0]),
    .tx_pop_try(ev[1]), .rx_read_try(ev[2]), .tx_write_try(ev[3]), .hold_out(hold_out),
    .hold_oe(hold_oe), .wp_out(wp_out), .wp_oe(wp_oe), .irq(irq), .xfer_active());

  qss_flash_model i_flash (.run(run), .hold_out(hold_out), .hold_oe(hold_oe),
    .wp_out(wp_out), .wp_oe(wp_oe), .link_clk(link_clk), .hold_pin(hold_pin),
    .wp_pin(wp_pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_raw(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_raw(a);
    check(rv & m, e);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 9'h000;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_bit(input int b, input int n);
    rv = 32'h0000_0000;
    for (int i = 0; i < n && rv[b] !== 1'b1; i++) rd_raw(QSS_OFF_STATUS);
    check({31'h0000_0000, rv[b]}, 32'h0000_0001);
  endtask

  task automatic wrap_up;
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end

  initial begin
    {rst, wr, rd, run, ev, addr, wdata, xfer_len, desc_idx} = '0;
    {desc_en, tx_dma_en, rx_dma_en, rx_full, tx_full, rx_count, tx_count} = '0;
    {close_en, desc_last} = 2'b00;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and pins
    rd_reg(QSS_OFF_SIDEBAND, 32'h0000_000F, 32'h0000_0005);
    rd_reg(QSS_OFF_STATUS, 32'h0F01_FF1F, 32'h0000_2000);
    rd_reg(QSS_OFF_COUNTS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_reg(QSS_OFF_IEN, 32'h0000_771F, 32'h0000_2000);
    check({30'h0, hold_oe, wp_oe}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0001);
    // Sideband drive
    wr_reg(QSS_OFF_SIDEBAND, 32'h0000_0008);
    check({29'h0, hold_oe, hold_pin, wp_oe}, 32'h0000_0004);
    wr_reg(QSS_OFF_SIDEBAND, 32'h0000_0002);
    check({29'h0, hold_oe, wp_oe, wp_pin}, 32'h0000_0002);
    rd_reg(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    // Counts and triggers
    rx_count <= 16'h0012;
    tx_count <= 16'h0034;
    repeat (3) @(posedge clk);
    rd_reg(QSS_OFF_COUNTS, 32'hFFFF_FFFF, 32'h0012_0034);
    rd_reg(QSS_OFF_STATUS, 32'h0000_7400, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wr_reg(QSS_OFF_TRIGGER, 32'h0012_0033);
    rd_reg(QSS_OFF_STATUS, 32'h0000_4400, 32'h0000_4000);
    tx_count <= 16'h0033;
    repeat (3) @(posedge clk);
    rd_reg(QSS_OFF_STATUS, 32'h0000_4400, 32'h0000_4400);
    wr_reg(QSS_OFF_IEN, 32'h0000_4000);
    check({31'h0, irq}, 32'h0000_0001);
    wr_reg(QSS_OFF_IEN, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    wr_reg(QSS_OFF_TRIGGER, 32'h0000_0000);
    wr_reg(QSS_OFF_STATUS, 32'h0000_4400);
    rd_reg(QSS_OFF_STATUS, 32'h0000_4400, 32'h0000_0000);
    // Sticky error flags
    {rx_full, tx_full, rx_count, tx_count} <= {2'b11, 32'h0000_0000};
    for (int i = 0; i < 5; i++) pulse(i);
    rd_reg(QSS_OFF_STATUS, 32'h0000_991C, 32'h0000_991C);
    wr_reg(QSS_OFF_STATUS, 32'h0000_0000);
    rd_reg(QSS_OFF_STATUS, 32'h0000_881C, 32'h0000_881C);
    wr_reg(QSS_OFF_STATUS, 32'h0000_881C);
    rd_reg(QSS_OFF_STATUS, 32'h0000_991C, 32'h0000_1100);
    {rx_full, tx_full} <= 2'b00;
    // Manual transfer of two bytes
    xfer_len <= 16'h0002;
    pulse(5);
    rd_reg(QSS_OFF_STATUS, 32'h0001_0001, 32'h0001_0000);
    run <= 1'b1;
    wait_bit(QSS_ST_XFER_DONE, 150);
    run <= 1'b0;
    rd_reg(QSS_OFF_STATUS, 32'h0001_0001, 32'h0000_0001);
    wr_reg(QSS_OFF_STATUS, 32'h0000_0001);
    // Stop in mid-byte of an endless transfer
    xfer_len <= 16'h0000;
    pulse(5);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    pulse(6);
    wait_bit(QSS_ST_XFER_DONE, 60);
    run <= 1'b0;
    wr_reg(QSS_OFF_STATUS, 32'h0000_0001);
    // DMA completion in both directions
    {tx_dma_en, rx_dma_en} <= 2'b11;
    close_en <= 1'b1;
    pulse(5);
    pulse(7);
    rd_reg(QSS_OFF_STATUS, 32'h0000_0003, 32'h0000_0000);
    pulse(8);
    rd_reg(QSS_OFF_STATUS, 32'h0000_0003, 32'h0000_0003);
    wr_reg(QSS_OFF_STATUS, 32'h0000_0003);
    // Descriptor chain, not on last entry
    desc_en  <= 1'b1;
    desc_idx <= 4'hA;
    close_en <= 1'b0;
    pulse(5);
    pulse(7);
    pulse(8);
    rd_reg(QSS_OFF_STATUS, 32'h0F00_0003, 32'h0A00_0002);
    // Last descriptor closes the chain
    wr_reg(QSS_OFF_STATUS, 32'h0000_0002);
    desc_last <= 1'b1;
    close_en  <= 1'b1;
    pulse(7);
    pulse(8);
    rd_reg(QSS_OFF_STATUS, 32'h0001_0003, 32'h0000_0003);
    wrap_up();
  end
endmodule // tb
